// ---- eqs_pkg.sv ----
// package: constants and types for the egress qos scheduler with wred
package eqs_pkg;
  // core clock and latency limit
  localparam int REF_CLK_MHZ = 10;
  localparam int LAT_LIMIT_US = 1000;
  localparam logic [15:0] LAT_CYC = 16'(LAT_LIMIT_US * REF_CLK_MHZ);
  // switch geometry
  localparam int NPORT = 9;
  localparam int NQUEUE = 2 * NPORT;
  localparam int QDEPTH = 128;
  localparam int QPTR_W = 7;
  localparam int MEM_AW = 12;
  localparam int MEM_DW = 24;
  localparam int MEM_WORDS = NQUEUE * QDEPTH;
  // register offsets on the plain register port
  localparam logic [4:0] ADDR_FLOOD_CTRL = 5'h00;
  localparam logic [4:0] ADDR_BUF_LOW_THR = 5'h01;
  localparam logic [4:0] ADDR_TX_SCHED = 5'h02;
  localparam logic [4:0] ADDR_VLAN_QMAP = 5'h03;
  localparam logic [4:0] ADDR_IP_QMAP = 5'h04;
  localparam logic [4:0] ADDR_VLAN_DMAP = 5'h05;
  localparam logic [4:0] ADDR_IP_DMAP = 5'h06;
  localparam logic [4:0] ADDR_LOW_RESERVE = 5'h07;
  localparam logic [4:0] ADDR_PORT_CTRL0 = 5'h08;
  localparam logic [4:0] ADDR_DROP_COUNT = 5'h11;
  // field positions
  localparam int FCR_PRI_SRC_BIT = 7;
  localparam int BUFFER_LOW_THRESHOLD_REG_TX_SUB_BIT = 6;
  localparam int BUFFER_LOW_THRESHOLD_REG_DROP_SUB_BIT = 7;
  localparam int BUFFER_LOW_THRESHOLD_REG_THR_MSB = 5;
  localparam int TRANSMIT_SCHEDULING_CONTROL_REG_QOS_EN_BIT = 5;
  localparam int TRANSMIT_SCHEDULING_CONTROL_REG_FC_OFF_BIT = 6;
  localparam int TRANSMIT_SCHEDULING_CONTROL_REG_HDX_QOS_BIT = 7;
  localparam int TRANSMIT_SCHEDULING_CONTROL_REG_WEIGHT_MSB = 3;
  localparam int PPC_FC_EN_BIT = 0;
  // values after reset
  localparam logic [7:0] FCR_RST = 8'h00;
  localparam logic [7:0] BUFFER_LOW_THRESHOLD_REG_RST = 8'h00;
  localparam logic [7:0] TRANSMIT_SCHEDULING_CONTROL_REG_RST = 8'h00;
  localparam logic [7:0] MAP_RST = 8'h00;
  localparam logic [7:0] LOW_DROP_RESERVE_THRESHOLD_RST = 8'h00;
  localparam logic [7:0] PPC_RST = 8'h00;
  localparam logic [7:0] LFSR_SEED = 8'h01;
  // wred occupancy thresholds
  localparam logic [7:0] WRED_L1_HIGH = 8'd24;
  localparam logic [7:0] WRED_L1_LOW = 8'd72;
  localparam logic [7:0] WRED_L2 = 8'd84;
  // dequeue states
  typedef enum logic [2:0] {
    DQ_IDLE = 3'b001,
    DQ_HIGH = 3'b010,
    DQ_LOW = 3'b100
  } eqs_dq_state_t;
endpackage : eqs_pkg

// ---- eqs_qmem.sv ----
// queue entry memory with registered read data
`timescale 1ns/1ps
module eqs_qmem (
  // clock
  input wire logic i_ref_clk,
  // write port
  input wire logic i_wr_en,
  input wire logic [eqs_pkg::MEM_AW-1:0] i_wr_addr,
  input wire logic [eqs_pkg::MEM_DW-1:0] i_wr_data,
  // read port
  input wire logic i_rd_en,
  input wire logic [eqs_pkg::MEM_AW-1:0] i_rd_addr,
  output logic [eqs_pkg::MEM_DW-1:0] o_rd_data
);
  import eqs_pkg::*;

  logic [MEM_DW-1:0] mem [0:MEM_WORDS-1];

  // write side
  always_ff @(posedge i_ref_clk) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
  end

  // read side, data one cycle later
  always_ff @(posedge i_ref_clk) begin
    if (i_rd_en) begin
      o_rd_data <= mem[i_rd_addr];
    end
  end
endmodule : eqs_qmem

// ---- eqs_top.sv ----
// egress qos: classification, two queues per port, wrr and wred
// What this block does
// - two transmit queues, high and low, per port
// - enqueue only after search result returns
// - select bit picks vlan tag or tos
// - threshold bit 6 picks tos transmit subfield
// - select bit also picks drop level source
// - threshold bit 7 picks tos drop subfield
// - vlan and tos maps give queue
// - vlan and tos maps give drop flag
// - scheduling bit 5 enables qos
// - high weight in bits 0-3, 1-15
// - weight highs then one low
// - half duplex single queue unless bit 7
// - latency limit forces high queue only
// - qos with flow control signals congestion
// - qos without flow control uses random drop
// - level 0: 50% high-drop, 0% low-drop
// - level 1: 24/72 buffers, 75%/25%
// - level 2: 84 buffers, 100%/50%
// - random drop only for non flow sources
// - qos off: one fifo queue per port
// - scheduling bit 6 disables all flow control
// - port control bit 0 enables port flow
`timescale 1ns/1ps
module eqs_top #(
  parameter logic [15:0] P_LAT_CYC = eqs_pkg::LAT_CYC
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // register port
  input wire logic [4:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  // search result from the frame engine
  input wire logic i_fwd_valid,
  input wire logic [3:0] i_fwd_dst_port,
  input wire logic [3:0] i_fwd_src_port,
  input wire logic i_fwd_vlan_tagged,
  input wire logic [2:0] i_fwd_vlan_pri,
  input wire logic i_fwd_is_ip,
  input wire logic [7:0] i_fwd_tos,
  input wire logic [7:0] i_fwd_handle,
  // buffer state and port duplex pins
  input wire logic [8:0] i_free_buffers,
  input wire logic [eqs_pkg::NPORT-1:0] i_port_half_duplex,
  // enqueue answer
  output logic o_enq_done,
  output logic o_enq_drop,
  output logic o_enq_high,
  output logic o_fc_req,
  output logic [3:0] o_fc_port,
  // transmit request and answer
  input wire logic i_tx_req,
  input wire logic [3:0] i_tx_port,
  output logic o_tx_valid,
  output logic o_tx_empty,
  output logic o_tx_high,
  output logic [3:0] o_tx_port,
  output logic [7:0] o_tx_handle
);
  import eqs_pkg::*;

  logic [7:0] flooding_control_reg;
  logic [7:0] buffer_low_threshold_reg;
  logic [7:0] transmit_scheduling_control_reg;
  logic [7:0] vlan_priority_queue_map;
  logic [7:0] ip_priority_queue_map;
  logic [7:0] vlan_drop_map;
  logic [7:0] ip_drop_map;
  logic [7:0] low_drop_reserve_threshold;
  logic [7:0] per_port_control_reg [NPORT];
  logic [7:0] drop_count;
  logic [NPORT-1:0] hdx_meta;
  logic [NPORT-1:0] hdx_sync;
  logic [7:0] lfsr;
  logic [15:0] now;
  logic [QPTR_W-1:0] wptr [NQUEUE];
  logic [QPTR_W-1:0] rptr [NQUEUE];
  logic [7:0] qcnt [NQUEUE];
  logic [3:0] hi_sent [NPORT];
  eqs_dq_state_t dq_state;
  logic [3:0] dq_port;
  logic [MEM_DW-1:0] rd_data;

  // port control register index
  logic [4:0] ppc_idx;
  assign ppc_idx = i_reg_addr - ADDR_PORT_CTRL0;

  // software register writes
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      flooding_control_reg <= FCR_RST;
      buffer_low_threshold_reg <= BUFFER_LOW_THRESHOLD_REG_RST;
      transmit_scheduling_control_reg <= TRANSMIT_SCHEDULING_CONTROL_REG_RST;
      vlan_priority_queue_map <= MAP_RST;
      ip_priority_queue_map <= MAP_RST;
      vlan_drop_map <= MAP_RST;
      ip_drop_map <= MAP_RST;
      low_drop_reserve_threshold <= LOW_DROP_RESERVE_THRESHOLD_RST;
      for (int p = 0; p < NPORT; p++) begin
        per_port_control_reg[p] <= PPC_RST;
      end
    end else if (i_reg_wr) begin
      unique case (i_reg_addr)
        ADDR_FLOOD_CTRL: flooding_control_reg <= i_reg_wdata;
        ADDR_BUF_LOW_THR: buffer_low_threshold_reg <= i_reg_wdata;
        ADDR_TX_SCHED: transmit_scheduling_control_reg <= i_reg_wdata;
        ADDR_VLAN_QMAP: vlan_priority_queue_map <= i_reg_wdata;
        ADDR_IP_QMAP: ip_priority_queue_map <= i_reg_wdata;
        ADDR_VLAN_DMAP: vlan_drop_map <= i_reg_wdata;
        ADDR_IP_DMAP: ip_drop_map <= i_reg_wdata;
        ADDR_LOW_RESERVE: low_drop_reserve_threshold <= i_reg_wdata;
        default: begin
          if (ppc_idx < 5'(NPORT)) begin
            per_port_control_reg[ppc_idx[3:0]] <= i_reg_wdata;
          end
        end
      endcase
    end
  end

  // register reads, data in the following cycle, unmapped reads zero
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      unique case (i_reg_addr)
        ADDR_FLOOD_CTRL: o_reg_rdata <= flooding_control_reg;
        ADDR_BUF_LOW_THR: o_reg_rdata <= buffer_low_threshold_reg;
        ADDR_TX_SCHED: o_reg_rdata <= transmit_scheduling_control_reg;
        ADDR_VLAN_QMAP: o_reg_rdata <= vlan_priority_queue_map;
        ADDR_IP_QMAP: o_reg_rdata <= ip_priority_queue_map;
        ADDR_VLAN_DMAP: o_reg_rdata <= vlan_drop_map;
        ADDR_IP_DMAP: o_reg_rdata <= ip_drop_map;
        ADDR_LOW_RESERVE: o_reg_rdata <= low_drop_reserve_threshold;
        ADDR_DROP_COUNT: o_reg_rdata <= drop_count;
        default: begin
          if (ppc_idx < 5'(NPORT)) begin
            o_reg_rdata <= per_port_control_reg[ppc_idx[3:0]];
          end else begin
            o_reg_rdata <= 8'h00;
          end
        end
      endcase
    end
  end

  // duplex pins come from the macs' link side: two-stage sync
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      hdx_meta <= '0;
      hdx_sync <= '0;
    end else begin
      hdx_meta <= i_port_half_duplex;
      hdx_sync <= hdx_meta;
    end
  end

  // random source for wred and free-running timestamp
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      lfsr <= LFSR_SEED;
      now <= 16'h0000;
    end else begin
      lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      now <= now + 16'h0001;
    end
  end

  // global control bits
  logic qos_en;
  logic fc_chip_off;
  logic [3:0] weight;
  assign qos_en = transmit_scheduling_control_reg[TRANSMIT_SCHEDULING_CONTROL_REG_QOS_EN_BIT];
  assign fc_chip_off = transmit_scheduling_control_reg[TRANSMIT_SCHEDULING_CONTROL_REG_FC_OFF_BIT];
  // weight 0 is not legal, it acts as 1
  assign weight = (transmit_scheduling_control_reg[TRANSMIT_SCHEDULING_CONTROL_REG_WEIGHT_MSB:0] == 4'h0)
    ? 4'h1 : transmit_scheduling_control_reg[TRANSMIT_SCHEDULING_CONTROL_REG_WEIGHT_MSB:0];

  // classification of the arriving search result
  logic priority_source_select;
  logic [2:0] tx_field;
  logic [2:0] drop_field;
  logic cls_high;
  logic cls_hdrop;
  logic dst_ok;
  logic port_qos;
  logic enq_high;
  logic [4:0] enq_q;
  logic fc_src;
  logic congested;
  logic [7:0] occ;
  logic lvl0;
  logic lvl1;
  logic lvl2;
  logic wred_hit;
  logic enq_drop;
  logic enq_push;
  logic [3:0] src_idx;

  always_comb begin
    src_idx = (i_fwd_src_port < 4'(NPORT)) ? i_fwd_src_port : 4'h0;
    priority_source_select = flooding_control_reg[FCR_PRI_SRC_BIT];
    // tos bit 0 is the msb: precedence [0:2], dtr [3:5]
    tx_field = buffer_low_threshold_reg[BUFFER_LOW_THRESHOLD_REG_TX_SUB_BIT]
      ? i_fwd_tos[7:5] : i_fwd_tos[4:2];
    drop_field = buffer_low_threshold_reg[BUFFER_LOW_THRESHOLD_REG_DROP_SUB_BIT]
      ? i_fwd_tos[7:5] : i_fwd_tos[4:2];
    cls_high = 1'b0;
    cls_hdrop = 1'b0;
    if (priority_source_select) begin
      if (i_fwd_is_ip) begin
        cls_high = ip_priority_queue_map[tx_field];
        cls_hdrop = ip_drop_map[drop_field];
      end
    end else if (i_fwd_vlan_tagged) begin
      cls_high = vlan_priority_queue_map[i_fwd_vlan_pri];
      cls_hdrop = vlan_drop_map[i_fwd_vlan_pri];
    end // untagged stays low queue, low drop
    dst_ok = i_fwd_dst_port < 4'(NPORT);
    // single fifo when qos is off or the port is half duplex without scheduling bit 7
    port_qos = qos_en && (!hdx_sync[i_fwd_dst_port[3:0] % 4'(NPORT)]
      || transmit_scheduling_control_reg[TRANSMIT_SCHEDULING_CONTROL_REG_HDX_QOS_BIT]);
    enq_high = port_qos && cls_high;
    enq_q = {i_fwd_dst_port, enq_high};
    fc_src = !fc_chip_off
      && per_port_control_reg[src_idx][PPC_FC_EN_BIT];
    congested = {1'b0, i_free_buffers}
      <= {4'h0, buffer_low_threshold_reg[BUFFER_LOW_THRESHOLD_REG_THR_MSB:0]};
    occ = dst_ok ? qcnt[enq_q % 5'(NQUEUE)] : 8'h00;
    lvl2 = occ >= WRED_L2;
    lvl1 = enq_high ? (occ >= WRED_L1_HIGH) : (occ >= WRED_L1_LOW);
    lvl0 = i_free_buffers <= {1'b0, low_drop_reserve_threshold};
    // drop odds from two random bits
    if (lvl2) begin
      wred_hit = cls_hdrop || lfsr[1];
    end else if (lvl1) begin
      wred_hit = cls_hdrop ? (lfsr[1:0] != 2'h3)
        : (lfsr[1:0] == 2'h0);
    end else if (lvl0) begin
      wred_hit = cls_hdrop && lfsr[1];
    end else begin
      wred_hit = 1'b0;
    end
    enq_drop = !dst_ok || (occ == 8'(QDEPTH))
      || (qos_en && !fc_src && wred_hit);
    enq_push = i_fwd_valid && !enq_drop;
  end

  // enqueue answer and flow control request
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_enq_done <= 1'b0;
      o_enq_drop <= 1'b0;
      o_enq_high <= 1'b0;
      o_fc_req <= 1'b0;
      o_fc_port <= 4'h0;
    end else begin
      o_enq_done <= i_fwd_valid;
      o_enq_drop <= i_fwd_valid && enq_drop;
      o_enq_high <= i_fwd_valid && enq_high;
      o_fc_req <= i_fwd_valid && qos_en && fc_src && congested;
      o_fc_port <= i_fwd_src_port;
    end
  end

  // saturating count of dropped packets
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      drop_count <= 8'h00;
    end else if (i_fwd_valid && enq_drop && drop_count != 8'hff) begin
      drop_count <= drop_count + 8'h01;
    end
  end

  // dequeue decisions
  logic [4:0] hq;
  logic [4:0] lq;
  logic [4:0] rq;
  logic [3:0] rp_port;
  logic aged;
  logic take_high;
  logic pop;
  logic [4:0] pop_q;
  logic rd_en;
  logic [MEM_AW-1:0] rd_addr;
  logic [3:0] hs;

  always_comb begin
    rp_port = (dq_state == DQ_IDLE) ? i_tx_port : dq_port;
    if (rp_port >= 4'(NPORT)) begin
      rp_port = 4'h0;
    end
    hq = {rp_port, 1'b1};
    lq = {rp_port, 1'b0};
    hs = hi_sent[rp_port];
    aged = (now - rd_data[23:8]) >= P_LAT_CYC;
    // over the limit only high goes, else weight highs per low
    take_high = aged || qcnt[lq] == 8'h00 || hs < weight;
    pop = 1'b0;
    pop_q = hq;
    rd_en = 1'b0;
    rq = hq;
    unique case (dq_state)
      DQ_IDLE: begin
        if (i_tx_req) begin
          rd_en = qcnt[hq] != 8'h00 || qcnt[lq] != 8'h00;
          rq = (qcnt[hq] != 8'h00) ? hq : lq;
        end
      end
      DQ_HIGH: begin
        pop = take_high;
        pop_q = hq;
        rd_en = !take_high;
        rq = lq;
      end
      DQ_LOW: begin
        pop = 1'b1;
        pop_q = lq;
      end
    endcase
    rd_addr = {rq, rptr[rq % 5'(NQUEUE)]};
  end

  // per-queue pointers and occupancy
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int q = 0; q < NQUEUE; q++) begin
        wptr[q] <= '0;
        rptr[q] <= '0;
        qcnt[q] <= 8'h00;
      end
    end else begin
      for (int q = 0; q < NQUEUE; q++) begin
        if (enq_push && enq_q == 5'(q)) begin
          wptr[q] <= wptr[q] + 7'h01;
        end
        if (pop && pop_q == 5'(q)) begin
          rptr[q] <= rptr[q] + 7'h01;
        end
        qcnt[q] <= qcnt[q] + 8'(enq_push && enq_q == 5'(q))
          - 8'(pop && pop_q == 5'(q));
      end
    end
  end

  // high packets sent since the last low one, per port
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int p = 0; p < NPORT; p++) begin
        hi_sent[p] <= 4'h0;
      end
    end else if (dq_state == DQ_HIGH) begin
      if (!take_high) begin
        hi_sent[dq_port] <= 4'h0;
      end else if (!aged && hs != 4'hf) begin
        hi_sent[dq_port] <= hs + 4'h1;
      end
    end
  end

  // dequeue state machine and transmit answer
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      dq_state <= DQ_IDLE;
      dq_port <= 4'h0;
      o_tx_valid <= 1'b0;
      o_tx_empty <= 1'b0;
      o_tx_high <= 1'b0;
      o_tx_port <= 4'h0;
      o_tx_handle <= 8'h00;
    end else begin
      o_tx_valid <= 1'b0;
      o_tx_empty <= 1'b0;
      unique case (dq_state)
        DQ_IDLE: begin
          if (i_tx_req) begin
            dq_port <= rp_port;
            o_tx_port <= rp_port;
            if (qcnt[hq] != 8'h00) begin
              dq_state <= DQ_HIGH;
            end else if (qcnt[lq] != 8'h00) begin
              dq_state <= DQ_LOW;
            end else begin
              o_tx_empty <= 1'b1;
            end
          end
        end
        DQ_HIGH: begin
          if (take_high) begin
            o_tx_valid <= 1'b1;
            o_tx_high <= 1'b1;
            o_tx_handle <= rd_data[7:0];
            dq_state <= DQ_IDLE;
          end else begin
            dq_state <= DQ_LOW;
          end
        end
        DQ_LOW: begin
          o_tx_valid <= 1'b1;
          o_tx_high <= 1'b0;
          o_tx_handle <= rd_data[7:0];
          dq_state <= DQ_IDLE;
        end
      endcase
    end
  end

  // entry store: timestamp above handle
  eqs_qmem u_qmem (
    .i_ref_clk(i_ref_clk),
    .i_wr_en(enq_push),
    .i_wr_addr({enq_q, wptr[enq_q % 5'(NQUEUE)]}),
    .i_wr_data({now, i_fwd_handle}),
    .i_rd_en(rd_en),
    .i_rd_addr(rd_addr),
    .o_rd_data(rd_data)
  );
endmodule : eqs_top

// ---- eqs_top_properties.sv ----
// port assertions for the egress qos block
`timescale 1ns/1ps
module eqs_top_chk (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // requests
  input wire logic i_fwd_valid,
  input wire logic [3:0] i_fwd_dst_port,
  input wire logic [3:0] i_fwd_src_port,
  input wire logic i_tx_req,
  input wire logic [3:0] i_tx_port,
  // answers
  input wire logic o_enq_done,
  input wire logic o_enq_drop,
  input wire logic o_fc_req,
  input wire logic [3:0] o_fc_port,
  input wire logic o_tx_valid,
  input wire logic o_tx_empty,
  input wire logic o_tx_high,
  input wire logic [3:0] o_tx_port
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rstn);
  // enqueue answers follow search results by one cycle
  property p_enq_ans; i_fwd_valid |=> o_enq_done; endproperty
  a_enq_ans: assert property (p_enq_ans)
    else $error("search result not answered");
  property p_enq_cause; o_enq_done |-> $past(i_fwd_valid); endproperty
  a_enq_cause: assert property (p_enq_cause)
    else $error("enqueue answer without search result");
  property p_bad_dst;
    i_fwd_valid && i_fwd_dst_port > 4'h8 |=> o_enq_drop;
  endproperty
  a_bad_dst: assert property (p_bad_dst)
    else $error("packet to missing port kept");
  property p_drop_done; o_enq_drop |-> o_enq_done; endproperty
  a_drop_done: assert property (p_drop_done)
    else $error("drop flag outside answer");
  property p_fc_port; o_enq_done |-> o_fc_port == $past(i_fwd_src_port);
  endproperty
  a_fc_port: assert property (p_fc_port)
    else $error("flow control port wrong");
  property p_fc_cause; o_fc_req |-> $past(i_fwd_valid); endproperty
  a_fc_cause: assert property (p_fc_cause)
    else $error("flow control request without packet");
  // transmit answers come within three cycles
  property p_tx_ans; i_tx_req |-> ##[1:3] (o_tx_valid || o_tx_empty);
  endproperty
  a_tx_ans: assert property (p_tx_ans)
    else $error("transmit request not answered");
  property p_empty_cause; o_tx_empty |-> $past(i_tx_req); endproperty
  a_empty_cause: assert property (p_empty_cause)
    else $error("empty answer without request");
  property p_tx_port; o_tx_valid |-> o_tx_port == $past(i_tx_port, 2);
  endproperty
  a_tx_port: assert property (p_tx_port)
    else $error("transmit answer for wrong port");
  // main scenarios
  c_drop: cover property (o_enq_drop);
  c_tx_high: cover property (o_tx_valid && o_tx_high);
  c_empty: cover property (o_tx_empty);
endmodule : eqs_top_chk

bind eqs_top eqs_top_chk u_chk (
  .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_fwd_valid(i_fwd_valid),
  .i_fwd_dst_port(i_fwd_dst_port), .i_fwd_src_port(i_fwd_src_port),
  .i_tx_req(i_tx_req), .i_tx_port(i_tx_port), .o_enq_done(o_enq_done),
  .o_enq_drop(o_enq_drop), .o_fc_req(o_fc_req), .o_fc_port(o_fc_port),
  .o_tx_valid(o_tx_valid), .o_tx_empty(o_tx_empty),
  .o_tx_high(o_tx_high), .o_tx_port(o_tx_port)
);

// ---- eqs_fe_mac.sv ----
// search result source and transmit mac model
`timescale 1ns/1ps
module eqs_fe_mac (
  // clock
  input wire logic i_ref_clk,
  // answers from the block
  input wire logic i_done,
  input wire logic i_drop,
  input wire logic i_high,
  input wire logic i_fc,
  input wire logic i_txv,
  input wire logic i_txe,
  input wire logic [7:0] i_txh,
  // search result
  output logic o_fv,
  output logic [3:0] o_dst,
  output logic [3:0] o_src,
  output logic o_tag,
  output logic [2:0] o_pri,
  output logic o_ip,
  output logic [7:0] o_tos,
  output logic [7:0] o_hnd,
  // transmit request
  output logic o_rq,
  output logic [3:0] o_rp
);
  logic [3:0] r; // done, drop, high, fc of last result
  logic [9:0] t; // empty, valid, handle of last pull
  // idle values at time zero
  initial begin
    {o_fv, o_dst, o_src, o_tag, o_pri, o_ip, o_tos, o_hnd} = '0;
    {o_rq, o_rp} = '0;
  end
  // one search result, answer sampled in the cycle after
  task automatic send(input logic [3:0] d, s, p, input logic ip,
      input logic [7:0] tos, h);
    @(posedge i_ref_clk);
    o_fv <= 1'b1;
    o_dst <= d;
    o_src <= s;
    o_tag <= p[3];
    o_pri <= p[2:0];
    o_ip <= ip;
    o_tos <= tos;
    o_hnd <= h;
    @(posedge i_ref_clk);
    o_fv <= 1'b0;
    o_tos <= ~tos; // fields no longer carry the packet
    o_hnd <= ~h;
    #1;
    r = {i_done, i_drop, i_high, i_fc};
  endtask : send
  // ask one port for its next packet, port held until answered
  task automatic pull(input logic [3:0] p);
    int k;
    @(posedge i_ref_clk);
    o_rq <= 1'b1;
    o_rp <= p;
    @(posedge i_ref_clk);
    o_rq <= 1'b0;
    #1;
    k = 0;
    while (i_txv !== 1'b1 && i_txe !== 1'b1 && k < 4) begin
      @(posedge i_ref_clk);
      #1;
      k++;
    end
    t = {i_txe, i_txv, i_txh};
  endtask : pull
endmodule : eqs_fe_mac

// ---- test_egress_qos_scheduler_wred.sv ----
// self-checking bench for the egress qos block
`timescale 1ns/1ps
module test_egress_qos_scheduler_wred;
  import eqs_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [4:0] ra = 5'h00;
  logic [7:0] rw = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [8:0] free = 9'h1ff;
  logic [8:0] hdx = 9'h020;
  logic [7:0] rdata, txh;
  logic fv, tag, ip, rq, done, drop, high, fc, txv, txe, txhi;
  logic [3:0] dst, src, rp, fcp, txp;
  logic [2:0] pri;
  logic [7:0] tos, hnd;
  int n_errors = 0;
  int num_checks = 0;
  always #50 clk = ~clk;
  // block under test and its far side
  eqs_top #(.P_LAT_CYC(16'd200)) dut (.i_ref_clk(clk), .i_rstn(rstn),
    .i_reg_addr(ra), .i_reg_wdata(rw), .i_reg_wr(wr_s), .i_reg_rd(rd_s),
    .o_reg_rdata(rdata), .i_fwd_valid(fv), .i_fwd_dst_port(dst),
    .i_fwd_src_port(src), .i_fwd_vlan_tagged(tag), .i_fwd_vlan_pri(pri),
    .i_fwd_is_ip(ip), .i_fwd_tos(tos), .i_fwd_handle(hnd),
    .i_free_buffers(free), .i_port_half_duplex(hdx), .o_enq_done(done),
    .o_enq_drop(drop), .o_enq_high(high), .o_fc_req(fc), .o_fc_port(fcp),
    .i_tx_req(rq), .i_tx_port(rp), .o_tx_valid(txv), .o_tx_empty(txe),
    .o_tx_high(txhi), .o_tx_port(txp), .o_tx_handle(txh));
  eqs_fe_mac far (.i_ref_clk(clk), .i_done(done), .i_drop(drop),
    .i_high(high), .i_fc(fc), .i_txv(txv), .i_txe(txe), .i_txh(txh),
    .o_fv(fv), .o_dst(dst), .o_src(src), .o_tag(tag), .o_pri(pri),
    .o_ip(ip), .o_tos(tos), .o_hnd(hnd), .o_rq(rq), .o_rp(rp));
  // shared compare
  task automatic chk(input string s, input logic [9:0] e, g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  // register write and read
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_s <= 1'b1;
    ra <= a;
    rw <= d;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    @(posedge clk);
    rd_s <= 1'b1;
    ra <= a;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk("register", {2'b00, e}, {2'b00, rdata});
  endtask : rd
  // search result with expected done, drop, high, fc
  task automatic enq(input logic [3:0] d, s, p, input logic i,
      input logic [7:0] t, h, input logic [3:0] e);
    far.send(d, s, p, i, t, h);
    chk("enqueue", {6'h00, e}, {6'h00, far.r});
  endtask : enq
  // transmit pull: 11'h200 empty, 11'h1hh low handle hh, 11'h5hh high
  task automatic pull(input logic [3:0] p, input logic [10:0] e);
    far.pull(p);
    chk("transmit", e[9:0], e[9] ? {far.t[9:8], 8'h00} : far.t);
    // queue flag only means something beside a valid packet
    if (e[8])
      chk("transmit high", {9'h000, e[10]}, {9'h000, txhi});
  endtask : pull
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up
  // watchdog
  initial begin
    repeat (6000) @(posedge clk);
    n_errors++;
    wrap_up();
  end
  // test sequence
  initial begin
    int n;
    logic [47:0] q;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 18; i++) rd(5'(i), 8'h00);
    wr(ADDR_DROP_COUNT, 8'h5a);
    rd(ADDR_DROP_COUNT, 8'h00);
    rd(5'h1f, 8'h00);
    $display("registers done");
    wr(ADDR_VLAN_QMAP, 8'hc0);
    far.send(4'h2, 4'h1, 4'h8, 1'b0, 8'h00, 8'h21);
    far.send(4'h2, 4'h1, 4'hf, 1'b0, 8'h00, 8'h22);
    pull(4'h2, 11'h121);
    pull(4'h2, 11'h122);
    pull(4'h2, 11'h200);
    $display("fifo done");
    wr(ADDR_TX_SCHED, 8'h22);
    rd(ADDR_TX_SCHED, 8'h22);
    for (int i = 0; i < 8; i++)
      enq(4'h3, 4'h1, {1'b1, 3'(i)}, 1'b0, 8'h00, 8'h30, {2'b10, i > 5, 1'b0});
    enq(4'h3, 4'h1, 4'h7, 1'b0, 8'h00, 8'h38, 4'b1000);
    enq(4'h9, 4'h1, 4'h8, 1'b0, 8'h00, 8'h39, 4'b1100);
    rd(ADDR_DROP_COUNT, 8'h01);
    for (int i = 0; i < 6; i++)
      far.send(4'h1, 4'h1, (i % 3) ? 4'hf : 4'h8, 1'b0, 8'h00, 8'(16 + i));
    q = 48'h11_12_10_14_15_13;
    for (int i = 0; i < 6; i++)
      pull(4'h1, {i % 3 != 2, 2'b01, q[47 - 8 * i -: 8]});
    pull(4'h1, 11'h200);
    far.send(4'h5, 4'h1, 4'h8, 1'b0, 8'h00, 8'h50);
    far.send(4'h5, 4'h1, 4'hf, 1'b0, 8'h00, 8'h51);
    pull(4'h5, 11'h150);
    pull(4'h5, 11'h151);
    wr(ADDR_TX_SCHED, 8'ha2);
    far.send(4'h5, 4'h1, 4'h8, 1'b0, 8'h00, 8'h52);
    far.send(4'h5, 4'h1, 4'hf, 1'b0, 8'h00, 8'h53);
    repeat (3) @(posedge clk);
    pull(4'h5, 11'h553);
    pull(4'h5, 11'h152);
    $display("scheduling done");
    wr(ADDR_TX_SCHED, 8'h21);
    far.send(4'h7, 4'h1, 4'hf, 1'b0, 8'h00, 8'h70);
    far.send(4'h7, 4'h1, 4'hf, 1'b0, 8'h00, 8'h71);
    far.send(4'h7, 4'h1, 4'h8, 1'b0, 8'h00, 8'h72);
    repeat (250) @(posedge clk);
    for (int i = 0; i < 3; i++)
      pull(4'h7, {i < 2, 10'h170 + 10'(i)});
    $display("latency done");
    wr(ADDR_FLOOD_CTRL, 8'h80);
    wr(ADDR_IP_QMAP, 8'h02);
    wr(ADDR_BUF_LOW_THR, 8'h40);
    enq(4'h8, 4'h1, 4'h0, 1'b1, 8'h20, 8'h80, 4'b1010);
    wr(ADDR_BUF_LOW_THR, 8'h00);
    enq(4'h8, 4'h1, 4'h0, 1'b1, 8'h20, 8'h81, 4'b1000);
    enq(4'h8, 4'h1, 4'h0, 1'b1, 8'h04, 8'h82, 4'b1010);
    enq(4'h8, 4'h1, 4'hf, 1'b0, 8'h04, 8'h83, 4'b1000);
    $display("tos select done");
    wr(ADDR_FLOOD_CTRL, 8'h00);
    wr(ADDR_VLAN_DMAP, 8'h80);
    wr(ADDR_LOW_RESERVE, 8'h10);
    free <= 9'h010;
    for (int i = 0; i < 8; i++)
      enq(4'h6, 4'h1, 4'h8, 1'b0, 8'h00, 8'h60, 4'b1000);
    n = 0;
    for (int i = 0; i < 16; i++) begin
      far.send(4'h6, 4'h1, 4'hf, 1'b0, 8'h00, 8'(i));
      n += int'(far.r[2]);
    end
    chk("level0 drops", 10'h001, {9'h000, n > 0 && n < 16});
    wr(ADDR_PORT_CTRL0, 8'h01);
    wr(ADDR_BUF_LOW_THR, 8'h20);
    enq(4'h6, 4'h0, 4'h8, 1'b0, 8'h00, 8'h61, 4'b1001);
    enq(4'h6, 4'h1, 4'h8, 1'b0, 8'h00, 8'h62, 4'b1000);
    free <= 9'h1ff;
    for (int i = 0; i < 84; i++)
      enq(4'h4, 4'h0, 4'he, 1'b0, 8'h00, 8'(i), 4'b1010);
    enq(4'h4, 4'h1, 4'hf, 1'b0, 8'h00, 8'h90, 4'b1110);
    enq(4'h4, 4'h0, 4'hf, 1'b0, 8'h00, 8'h91, 4'b1010);
    // level 1: high queue below 24 keeps high-drop, from 24 on drops
    for (int i = 0; i < 23; i++)
      enq(4'h0, 4'h0, 4'he, 1'b0, 8'h00, 8'(i), 4'b1010);
    enq(4'h0, 4'h1, 4'hf, 1'b0, 8'h00, 8'h17, 4'b1010);
    n = 0;
    for (int i = 0; i < 16; i++) begin
      far.send(4'h0, 4'h1, 4'hf, 1'b0, 8'h00, 8'(i));
      n += int'(far.r[2]);
    end
    chk("level1 drops", 10'h001, {9'h000, n > 0});
    wr(ADDR_FLOOD_CTRL, 8'h80);
    wr(ADDR_IP_QMAP, 8'hff);
    wr(ADDR_IP_DMAP, 8'h02);
    wr(ADDR_BUF_LOW_THR, 8'h80);
    enq(4'h4, 4'h1, 4'h0, 1'b1, 8'h20, 8'h92, 4'b1110);
    wr(ADDR_BUF_LOW_THR, 8'h00);
    enq(4'h4, 4'h1, 4'h0, 1'b1, 8'h04, 8'h93, 4'b1110);
    wr(ADDR_FLOOD_CTRL, 8'h00);
    wr(ADDR_TX_SCHED, 8'h62);
    enq(4'h4, 4'h0, 4'hf, 1'b0, 8'h00, 8'h94, 4'b1110);
    $display("drop levels done");
    wrap_up();
  end
endmodule : test_egress_qos_scheduler_wred
